// >>> shared/fsl_pkg.sv
// constants and types shared by the fieldbus status indicator block
package fsl_pkg;
  // system clock and base tick of the indicator patterns
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 50;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  // pattern timing in ticks
  localparam int BLINK_TICKS = 4;
  localparam int FLASH_TICKS = 4;
  localparam int FRAME_TICKS = 24;
  localparam int ACT_HOLD_TICKS = 2;
  // two network ports
  localparam int NUM_PORTS = 2;
  // single precision field layout
  localparam int FLT_MAN_W = 23;
  localparam logic [7:0] FLT_BIAS = 8'h7F;
  localparam logic [31:0] WEIGHT_RST = 32'h0000_0000;
  // slave state machine state as seen by the indicators
  typedef enum logic [1:0] {
    FSL_INIT,
    FSL_PREOP,
    FSL_SAFEOP,
    FSL_OP
  } fsl_ecat_t;
endpackage

// >>> hdl/fsl_pattern.sv
// tick divider and blink, flash and flicker pattern generator
`timescale 1ns/10ps
module fsl_pattern #(
  parameter int TICK_CYCLES = fsl_pkg::TICK_CYCLES,
  parameter int BLINK_TICKS = fsl_pkg::BLINK_TICKS,
  parameter int FLASH_TICKS = fsl_pkg::FLASH_TICKS,
  parameter int FRAME_TICKS = fsl_pkg::FRAME_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // patterns
  output logic tick_q,
  output logic blink_q,
  output logic single_q,
  output logic double_q,
  output logic flicker_q
);
  import fsl_pkg::*;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam int FW = $clog2(FRAME_TICKS + 1);
  logic [CW-1:0] div_q;
  logic [FW-1:0] frame_q;

  // one divider sets every pattern, so all lamps stay in phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == CW'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + CW'(1);
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_q <= '0;
      flicker_q <= 1'b0;
    end else if (tick_q) begin
      frame_q <= (frame_q == FW'(FRAME_TICKS - 1)) ? '0 : frame_q + FW'(1);
      flicker_q <= ~flicker_q;
    end
  end

  // frame: blink alternates every BLINK_TICKS; single is flash on, long gap; double is flash on, gap, flash on, long gap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_q <= 1'b0;
      single_q <= 1'b0;
      double_q <= 1'b0;
    end else begin
      blink_q <= ((frame_q / FW'(BLINK_TICKS)) % FW'(2)) == FW'(0);
      single_q <= frame_q < FW'(FLASH_TICKS);
      double_q <= (frame_q < FW'(FLASH_TICKS)) ||
                  (frame_q >= FW'(2 * FLASH_TICKS) && frame_q < FW'(3 * FLASH_TICKS));
    end
  end
endmodule

// >>> hdl/fsl_top.sv
// fieldbus status indicators and weight value format selection
`timescale 1ns/10ps
module fsl_top #(
  parameter int TICK_CYCLES = fsl_pkg::TICK_CYCLES,
  parameter int ACT_HOLD_TICKS = fsl_pkg::ACT_HOLD_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // slave state and fatal condition from the interface controller
  input wire fsl_pkg::fsl_ecat_t slave_state,
  input wire logic fatal_event,
  // error conditions, levels held while present
  input wire logic cfg_invalid,
  input wire logic unsol_change,
  input wire logic wdog_timeout,
  input wire logic ctrl_fail,
  // port status from the phys, asynchronous
  input wire logic [fsl_pkg::NUM_PORTS-1:0] link_up,
  input wire logic [fsl_pkg::NUM_PORTS-1:0] link_act,
  // weight value in and format setting
  input wire logic signed [31:0] weight_in,
  input wire logic weight_stb,
  input wire logic fmt_float,
  // lamps
  output logic run_green_q,
  output logic run_red_q,
  output logic err_red_q,
  output logic [fsl_pkg::NUM_PORTS-1:0] link_green_q,
  // reported weight
  output logic [31:0] weight_out_q,
  output logic weight_vld_q
);
  import fsl_pkg::*;
  localparam int HW = $clog2(ACT_HOLD_TICKS + 2);

  logic tick;
  logic pat_blink;
  logic pat_single;
  logic pat_double;
  logic pat_flicker;
  logic [NUM_PORTS-1:0] link_s1_q;
  logic [NUM_PORTS-1:0] link_s2_q;
  logic [NUM_PORTS-1:0] act_s1_q;
  logic [NUM_PORTS-1:0] act_s2_q;
  logic [NUM_PORTS-1:0] act_s3_q;
  logic [HW-1:0] hold_q [NUM_PORTS];
  logic run_green_d;
  logic run_red_d;
  logic err_red_d;

  fsl_pattern #(
    .TICK_CYCLES(TICK_CYCLES),
    .BLINK_TICKS(BLINK_TICKS),
    .FLASH_TICKS(FLASH_TICKS),
    .FRAME_TICKS(FRAME_TICKS)
  ) u_pattern (
    .clk(clk),
    .rstn(rstn),
    .tick_q(tick),
    .blink_q(pat_blink),
    .single_q(pat_single),
    .double_q(pat_double),
    .flicker_q(pat_flicker)
  );

  // truncating conversion: magnitudes above 24 bits lose their low bits
  function automatic logic [31:0] fsl_int_to_float(input logic signed [31:0] v);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0] msb;
    logic [7:0] expo;
    mag = v[31] ? (~v + 32'h0000_0001) : v;
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = i[4:0];
      end
    end
    norm = mag << (5'h1F - msb);
    expo = FLT_BIAS + {3'h0, msb};
    if (mag == 32'h0000_0000) begin
      return 32'h0000_0000;
    end
    return {v[31], expo, norm[30:30-FLT_MAN_W+1]};
  endfunction

  // run lamp: fatal overrides the state display
  always_comb begin
    run_green_d = 1'b0;
    run_red_d = 1'b0;
    if (fatal_event) begin
      run_red_d = 1'b1;
    end else begin
      case (slave_state)
        FSL_INIT: run_green_d = 1'b0;
        FSL_PREOP: run_green_d = pat_blink;
        FSL_SAFEOP: run_green_d = pat_single;
        FSL_OP: run_green_d = 1'b1;
        default: run_green_d = 1'b0;
      endcase
    end
  end

  // error lamp: the most severe condition present wins
  always_comb begin
    if (ctrl_fail) begin
      err_red_d = 1'b1;
    end else if (wdog_timeout) begin
      err_red_d = pat_double;
    end else if (cfg_invalid) begin
      err_red_d = pat_blink;
    end else if (unsol_change) begin
      err_red_d = pat_single;
    end else begin
      err_red_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_green_q <= 1'b0;
      run_red_q <= 1'b0;
      err_red_q <= 1'b0;
    end else begin
      run_green_q <= run_green_d;
      run_red_q <= run_red_d;
      err_red_q <= err_red_d;
    end
  end

  // phy status is asynchronous to clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_s1_q <= '0;
      link_s2_q <= '0;
      act_s1_q <= '0;
      act_s2_q <= '0;
      act_s3_q <= '0;
    end else begin
      link_s1_q <= link_up;
      link_s2_q <= link_s1_q;
      act_s1_q <= link_act;
      act_s2_q <= act_s1_q;
      act_s3_q <= act_s2_q;
    end
  end

  // any activity edge on a linked port restarts the hold, so short bursts still show a flicker
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        hold_q[p] <= '0;
      end else if (!link_s2_q[p]) begin
        hold_q[p] <= '0;
      end else if (act_s2_q[p] != act_s3_q[p]) begin
        hold_q[p] <= HW'(ACT_HOLD_TICKS + 1);
      end else if (tick && hold_q[p] != '0) begin
        hold_q[p] <= hold_q[p] - HW'(1);
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        link_green_q[p] <= 1'b0;
      end else if (!link_s2_q[p]) begin
        link_green_q[p] <= 1'b0;
      end else if (hold_q[p] != '0) begin
        link_green_q[p] <= pat_flicker;
      end else begin
        link_green_q[p] <= 1'b1;
      end
    end

    link_dark_a: assert property (@(posedge clk) disable iff (!rstn)
      !link_s2_q[p] |=> !link_green_q[p])
      else $error("port lamp lit without link");
    link_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      (link_s2_q[p] && hold_q[p] == '0) |=> link_green_q[p])
      else $error("idle link lamp not steady");
    link_flick_a: assert property (@(posedge clk) disable iff (!rstn)
      (link_s2_q[p] && hold_q[p] != '0) |=> link_green_q[p] == $past(pat_flicker))
      else $error("busy link lamp not flickering");
  end

  // format is sampled with each new weight value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      weight_out_q <= WEIGHT_RST;
      weight_vld_q <= 1'b0;
    end else begin
      weight_vld_q <= weight_stb;
      if (weight_stb) begin
        weight_out_q <= fmt_float ? fsl_int_to_float(weight_in) : weight_in;
      end
    end
  end

  run_init_a: assert property (@(posedge clk) disable iff (!rstn)
    (slave_state == FSL_INIT && !fatal_event) |=> (!run_green_q && !run_red_q))
    else $error("run lamp lit in init");
  run_op_a: assert property (@(posedge clk) disable iff (!rstn)
    (slave_state == FSL_OP && !fatal_event) |=> (run_green_q && !run_red_q))
    else $error("run lamp not steady in operational");
  run_fatal_a: assert property (@(posedge clk) disable iff (!rstn)
    fatal_event |=> (run_red_q && !run_green_q))
    else $error("run lamp not red on fatal");
  run_safeop_a: assert property (@(posedge clk) disable iff (!rstn)
    (slave_state == FSL_SAFEOP && !fatal_event) |=> run_green_q == $past(pat_single))
    else $error("run lamp not single flash");
  run_preop_a: assert property (@(posedge clk) disable iff (!rstn)
    (slave_state == FSL_PREOP && !fatal_event) |=> (run_green_q == $past(pat_blink) && !run_red_q))
    else $error("run lamp not blinking in pre-operational");
  err_cfg_a: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_invalid && !ctrl_fail && !wdog_timeout) |=> err_red_q == $past(pat_blink))
    else $error("error lamp not blinking on bad config");
  err_unsol_a: assert property (@(posedge clk) disable iff (!rstn)
    (unsol_change && !cfg_invalid && !ctrl_fail && !wdog_timeout) |=> err_red_q == $past(pat_single))
    else $error("error lamp not single flash");
  err_wdog_a: assert property (@(posedge clk) disable iff (!rstn)
    (wdog_timeout && !ctrl_fail) |=> err_red_q == $past(pat_double))
    else $error("error lamp not double flash");
  err_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (!ctrl_fail && !wdog_timeout && !cfg_invalid && !unsol_change) |=> !err_red_q)
    else $error("error lamp lit without error");
  err_fail_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_fail |=> err_red_q)
    else $error("error lamp not steady on controller failure");
  weight_fmt_a: assert property (@(posedge clk) disable iff (!rstn)
    (weight_stb && !fmt_float) |=> (weight_vld_q && weight_out_q == $past(weight_in)))
    else $error("integer weight not passed through");
  weight_flt_a: assert property (@(posedge clk) disable iff (!rstn)
    (weight_stb && fmt_float && weight_in == 32'sh0000_0001) |=> weight_out_q == 32'h3F80_0000)
    else $error("float weight of one wrong");
endmodule

// >>> tb/fsl_far_end.sv
// far side model: two network ports with link presence and traffic
`timescale 1ns/10ps
module fsl_far_end (
  // control from the bench
  input wire logic [1:0] link_on,
  input wire logic [1:0] traffic,
  // port status toward the block
  output logic [1:0] link_up,
  output logic [1:0] link_act
);
  initial link_act = 2'h0;
  assign link_up = link_on;
  // frames arrive off the system clock grid, hence the odd periods
  always #13 if (traffic[0] && link_on[0]) link_act[0] = ~link_act[0];
  // port 1 may chatter without a link, which the block must ignore
  always #17 if (traffic[1]) link_act[1] = ~link_act[1];
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the fieldbus status indicators
`timescale 1ns/10ps
module tb_top;
  import fsl_pkg::*;
  localparam int FRAME = 96; // 24 ticks of 4 cycles
  logic clk, rstn, fatal_event, cfg_invalid, unsol_change, wdog_timeout, ctrl_fail;
  logic weight_stb, fmt_float, run_green_q, run_red_q, err_red_q, weight_vld_q;
  fsl_ecat_t slave_state;
  logic [1:0] link_on, traffic, link_up, link_act, link_green_q;
  logic signed [31:0] weight_in;
  logic [31:0] weight_out_q;
  int error_cnt = 0;
  int num_checks = 0;

  fsl_top #(.TICK_CYCLES(4), .ACT_HOLD_TICKS(1)) i_fsl_top (
    .clk(clk), .rstn(rstn), .slave_state(slave_state), .fatal_event(fatal_event),
    .cfg_invalid(cfg_invalid), .unsol_change(unsol_change), .wdog_timeout(wdog_timeout),
    .ctrl_fail(ctrl_fail), .link_up(link_up), .link_act(link_act), .weight_in(weight_in),
    .weight_stb(weight_stb), .fmt_float(fmt_float), .run_green_q(run_green_q),
    .run_red_q(run_red_q), .err_red_q(err_red_q), .link_green_q(link_green_q),
    .weight_out_q(weight_out_q), .weight_vld_q(weight_vld_q));

  fsl_far_end i_fsl_far_end (.link_on(link_on), .traffic(traffic), .link_up(link_up), .link_act(link_act));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // lit cycles over one whole frame do not depend on the pattern phase
  task automatic lamp_on(input int sel, input int exp);
    int n;
    logic v;
    n = 0;
    repeat (8) @(posedge clk);
    repeat (FRAME) begin
      @(negedge clk);
      case (sel)
        0: v = run_green_q;
        1: v = run_red_q;
        2: v = err_red_q;
        default: v = link_green_q[sel-3];
      endcase
      // an unknown lamp level must never pass as dark
      n += (v === 1'b1) ? 1 : ((v === 1'b0) ? 0 : FRAME + 1);
    end
    // return on a rising edge so that callers drive their inputs there
    @(posedge clk);
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_run();
    fsl_ecat_t st [4] = '{FSL_INIT, FSL_OP, FSL_PREOP, FSL_SAFEOP};
    int g [4] = '{0, 96, 48, 16};
    for (int i = 0; i < 4; i++) begin
      slave_state <= st[i];
      lamp_on(0, g[i]);
      lamp_on(1, 0);
    end
    fatal_event <= 1'b1;
    lamp_on(1, 96);
    lamp_on(0, 0);
    fatal_event <= 1'b0;
  endtask

  task automatic t_err();
    lamp_on(2, 0);
    unsol_change <= 1'b1;
    lamp_on(2, 16);
    cfg_invalid <= 1'b1;
    lamp_on(2, 48);
    wdog_timeout <= 1'b1;
    lamp_on(2, 32);
    ctrl_fail <= 1'b1;
    lamp_on(2, 96);
    {ctrl_fail, wdog_timeout, cfg_invalid, unsol_change} <= 4'h0;
    lamp_on(2, 0);
  endtask

  task automatic t_link();
    traffic <= 2'h2;
    lamp_on(4, 0);
    link_on <= 2'h1;
    lamp_on(3, 96);
    link_on <= 2'h3;
    traffic <= 2'h3;
    lamp_on(3, 48);
    lamp_on(4, 48);
  endtask

  task automatic t_weight();
    logic [31:0] wi [7] = '{32'hFFFFFFFB, 32'h00000001, 32'hFFFFFFFE, 32'h00000000,
                            32'h00000064, 32'h01000001, 32'h80000000};
    logic [31:0] wo [7] = '{32'hFFFFFFFB, 32'h3F800000, 32'hC0000000, 32'h00000000,
                            32'h42C80000, 32'h4B800000, 32'hCF000000};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      weight_in <= wi[i];
      fmt_float <= (i != 0);
      weight_stb <= 1'b1;
      @(posedge clk);
      weight_stb <= 1'b0;
      #1;
      chk({31'h0, weight_vld_q}, 32'h1);
      chk(weight_out_q, wo[i]);
      @(posedge clk);
      #1;
      chk({31'h0, weight_vld_q}, 32'h0);
      chk(weight_out_q, wo[i]);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the tests need about 2130 cycles
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    slave_state = FSL_INIT;
    {fatal_event, cfg_invalid, unsol_change, wdog_timeout, ctrl_fail} = 5'h00;
    {weight_stb, fmt_float} = 2'h0;
    weight_in = 32'h00000000;
    link_on = 2'h0;
    traffic = 2'h0;
    repeat (10) @(posedge clk);
    chk(32'({run_green_q, run_red_q, err_red_q, link_green_q, weight_vld_q}), 32'h0);
    chk(weight_out_q, WEIGHT_RST);
    rstn <= 1'b1;
    t_run();
    t_err();
    t_link();
    t_weight();
    complete_run();
  end
endmodule
